/* File: rtl/cfg_load_port.sv */
/*
  Passive parallel configuration load port: APB register slave, load
  sequencer on pclk, word counter on the host-driven cfg_clk.
  Assumes the host drives cfg_clk and cfg_data, and that open-drain
  pins are resolved outside from the output enables.
*/
`timescale 1ns/100ps
// How it works
// - x8: one clock per word, two with decompression
// - x16: ratio 1, 2 encrypted, 4 decompressed
// - User mode: all pins high; request low restarts
// - Status held low through power-on delay
// - Load-complete low until image fully received
// - Release complete; init starts, two falling edges needed for user mode
// - Init-done pin low until initialization ends
// - Oscillator init: user mode 175..437 us after complete
// - User clock switch at least four periods after
// - User mode after switch plus 8576 user clocks
// - Widest path 32 bits per clock
// - Data sampled on cfg_clk rising edge
// - Status low within 600 ns of request
module cfg_load_port #(
  parameter int POR_CYCLES  = cfg_load_pkg::POR_DELAY_CYCLES,
  parameter int INIT_CYCLES = cfg_load_pkg::OSC_INIT_MIN_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cfg_clk,
  input  wire logic [31:0] cfg_data,
  input  wire logic        config_req_n,
  input  wire logic        user_startup_clk,
  input  wire logic        status_n_i,
  output logic             status_n_o,
  output logic             status_n_oe_n,
  input  wire logic        load_done_i,
  output logic             load_done_o,
  output logic             load_done_oe_n,
  input  wire logic        init_done_i,
  output logic             init_done_o,
  output logic             init_done_oe_n
);

  // ---------------- pclk domain: registers ----------------
  logic [5:0]  ctrl_q;
  logic [31:0] image_bits_q;
  logic [5:0]  shadow_ctrl_q;
  logic [31:0] shadow_bits_q;
  logic [31:0] checksum_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  cfg_load_pkg::cfg_state_t state_q, state_d;

  logic        arm_q;
  logic [31:0] timer_q;
  logic [15:0] uclk_cnt_q;
  logic        switched_q;
  logic        uclk_prev_q;
  logic        done_seen_q;
  logic        status_oe_n_q;
  logic        done_oe_n_q;
  logic        initpin_oe_n_q;

  // Synchronised pins and link-domain levels
  logic [6:0]  pin_async;
  logic [6:0]  pin_s;
  logic        req_n_s;
  logic        status_s;
  logic        done_pin_s;
  logic        initpin_s;
  logic        uclk_s;
  logic        link_done_s;
  logic        link_falls_s;

  // Link-domain signals
  logic        arm_l;
  logic [2:0]  phase_q;
  logic [31:0] bits_q;
  logic [31:0] link_sum_q;
  logic        link_done_q;
  logic [1:0]  falls_q;
  logic        falls_ok_q;

  assign pin_async = {config_req_n, status_n_i, load_done_i, init_done_i, user_startup_clk, link_done_q, falls_ok_q};

  sync2 #(
    .W (7)
  ) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pin_async),
    .q     (pin_s)
  );

  assign req_n_s      = pin_s[6];
  assign status_s     = pin_s[5];
  assign done_pin_s   = pin_s[4];
  assign initpin_s    = pin_s[3];
  assign uclk_s       = pin_s[2];
  assign link_done_s  = pin_s[1];
  assign link_falls_s = pin_s[0];

  // APB decode
  wire        apb_access  = psel && penable;
  wire        apb_done    = apb_access && pready_q;
  wire        hit_ctrl    = (paddr == cfg_load_pkg::ADDR_CTRL);
  wire        hit_bits    = (paddr == cfg_load_pkg::ADDR_IMAGE_BITS);
  wire        hit_status  = (paddr == cfg_load_pkg::ADDR_STATUS);
  wire        hit_sum     = (paddr == cfg_load_pkg::ADDR_CHECKSUM);
  wire        addr_ok     = hit_ctrl || hit_bits || hit_status || hit_sum;
  wire        ro_write    = pwrite && (hit_status || hit_sum);
  wire        wr_ctrl     = apb_done && pwrite && hit_ctrl;
  wire        wr_bits     = apb_done && pwrite && hit_bits;
  wire [31:0] status_word = {22'h00_0000, initpin_s, done_pin_s, status_s, req_n_s,
                             link_falls_s, link_done_s, arm_q, state_q};
  wire [31:0] rd_mux      = hit_ctrl   ? {26'h0000000, ctrl_q} :
                            hit_bits   ? image_bits_q :
                            hit_status ? status_word :
                            hit_sum    ? checksum_q : 32'h0000_0000;

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_access && !pready_q;
      pslverr_q <= apb_access && !pready_q && (!addr_ok || ro_write);
      prdata_q  <= (apb_access && !pready_q && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q       <= cfg_load_pkg::CTRL_RESET;
      image_bits_q <= cfg_load_pkg::IMAGE_BITS_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[cfg_load_pkg::CTRL_BITS-1:0];
      end
      if (wr_bits) begin
        image_bits_q <= pwdata;
      end
    end
  end

  // ---------------- pclk domain: load sequencer ----------------
  wire use_uclk    = shadow_ctrl_q[cfg_load_pkg::CTRL_USERCLK_BIT];
  wire initpin_en  = shadow_ctrl_q[cfg_load_pkg::CTRL_INITPIN_BIT];
  wire por_over    = (timer_q >= 32'(POR_CYCLES));
  wire osc_over    = (timer_q >= 32'(INIT_CYCLES));
  wire switch_over = (timer_q >= 32'(cfg_load_pkg::USERCLK_SWITCH_CYCLES));
  wire uclk_rise   = uclk_s && !uclk_prev_q;
  wire uclk_over   = (uclk_cnt_q >= 16'(cfg_load_pkg::USERCLK_INIT_EDGES));
  wire init_over   = use_uclk ? (switched_q && uclk_over) : osc_over;
  // Load seen from link_done_s held two cycles; the wired-AND pin is not read
  wire load_seen   = link_done_s && done_seen_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cfg_load_pkg::ST_POR: begin
        if (por_over) begin
          state_d = req_n_s ? cfg_load_pkg::ST_LOAD : cfg_load_pkg::ST_RESET;
        end
      end
      cfg_load_pkg::ST_RESET: begin
        if (req_n_s) begin
          state_d = cfg_load_pkg::ST_LOAD;
        end
      end
      cfg_load_pkg::ST_LOAD: begin
        if (!req_n_s) begin
          state_d = cfg_load_pkg::ST_RESET;
        end else if (load_seen) begin
          state_d = cfg_load_pkg::ST_INIT;
        end
      end
      cfg_load_pkg::ST_INIT: begin
        if (!req_n_s) begin
          state_d = cfg_load_pkg::ST_RESET;
        end else if (init_over && link_falls_s) begin
          state_d = cfg_load_pkg::ST_USER;
        end
      end
      cfg_load_pkg::ST_USER: begin
        if (!req_n_s) begin
          state_d = cfg_load_pkg::ST_RESET;
        end
      end
      default: begin
        state_d = cfg_load_pkg::ST_POR;
      end
    endcase
  end

  wire entering_load = (state_d == cfg_load_pkg::ST_LOAD) && (state_q != cfg_load_pkg::ST_LOAD);
  wire entering_init = (state_d == cfg_load_pkg::ST_INIT) && (state_q != cfg_load_pkg::ST_INIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q       <= cfg_load_pkg::ST_POR;
      timer_q       <= 32'h0000_0000;
      shadow_ctrl_q <= cfg_load_pkg::CTRL_RESET;
      shadow_bits_q <= cfg_load_pkg::IMAGE_BITS_RESET;
      arm_q         <= 1'b0;
      done_seen_q   <= 1'b0;
      checksum_q    <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      if (entering_load || entering_init) begin
        timer_q <= 32'h0000_0000;
      end else if (timer_q != 32'hFFFF_FFFF) begin
        timer_q <= timer_q + 32'h0000_0001;
      end
      // Settings frozen before the link is armed; stable while armed
      if (entering_load) begin
        shadow_ctrl_q <= ctrl_q;
        shadow_bits_q <= image_bits_q;
      end
      arm_q <= (state_d == cfg_load_pkg::ST_LOAD || state_d == cfg_load_pkg::ST_INIT ||
                state_d == cfg_load_pkg::ST_USER) && !entering_load && status_s;
      done_seen_q <= link_done_s && (state_q == cfg_load_pkg::ST_LOAD);
      if (link_done_s && !done_seen_q && state_q == cfg_load_pkg::ST_LOAD) begin
        checksum_q <= link_sum_q;
      end
    end
  end

  // User start-up clock edges, counted after the switch-over delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uclk_prev_q <= 1'b0;
      switched_q  <= 1'b0;
      uclk_cnt_q  <= 16'h0000;
    end else begin
      uclk_prev_q <= uclk_s;
      if (state_q != cfg_load_pkg::ST_INIT) begin
        switched_q <= 1'b0;
        uclk_cnt_q <= 16'h0000;
      end else begin
        if (switch_over) begin
          switched_q <= 1'b1;
        end
        if (switched_q && uclk_rise && !uclk_over) begin
          uclk_cnt_q <= uclk_cnt_q + 16'h0001;
        end
      end
    end
  end

  // Open-drain pin drive, enable low while pulling low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_oe_n_q  <= 1'b0;
      done_oe_n_q    <= 1'b0;
      initpin_oe_n_q <= 1'b1;
    end else begin
      status_oe_n_q  <= (state_d != cfg_load_pkg::ST_POR) && (state_d != cfg_load_pkg::ST_RESET);
      done_oe_n_q    <= (state_d == cfg_load_pkg::ST_INIT) || (state_d == cfg_load_pkg::ST_USER) ||
                        ((state_d == cfg_load_pkg::ST_LOAD) && link_done_s);
      initpin_oe_n_q <= !(initpin_en && (state_d == cfg_load_pkg::ST_INIT ||
                        (state_d == cfg_load_pkg::ST_LOAD && link_done_s)));
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign status_n_oe_n  = status_oe_n_q;
  assign load_done_oe_n = done_oe_n_q;
  assign init_done_oe_n = initpin_oe_n_q;

  logic pin_low_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_low_q <= 1'b0;
    end else begin
      pin_low_q <= 1'b0;
    end
  end
  assign status_n_o  = pin_low_q;
  assign load_done_o = pin_low_q;
  assign init_done_o = pin_low_q;

  // ---------------- cfg_clk domain: word counter ----------------
  // Disarm clears the link at once, even with cfg_clk stopped
  sync2 #(
    .W (1)
  ) u_arm_sync (
    .clk   (cfg_clk),
    .rst_n (arm_q),
    .d     (1'b1),
    .q     (arm_l)
  );

  wire [1:0]  l_width  = shadow_ctrl_q[cfg_load_pkg::CTRL_WIDTH_LSB+1:cfg_load_pkg::CTRL_WIDTH_LSB];
  wire [2:0]  l_ratio  = cfg_load_pkg::ratio_of(l_width, shadow_ctrl_q[cfg_load_pkg::CTRL_DECOMP_BIT],
                                                shadow_ctrl_q[cfg_load_pkg::CTRL_ENCRYPT_BIT]);
  wire [5:0]  l_wbits  = cfg_load_pkg::bits_of(l_width);
  wire        l_word   = (phase_q == l_ratio - 3'h1);
  wire [31:0] l_next   = bits_q + {26'h0000000, l_wbits};

  always_ff @(posedge cfg_clk or negedge arm_l) begin
    if (!arm_l) begin
      phase_q     <= 3'h0;
      bits_q      <= 32'h0000_0000;
      link_sum_q  <= 32'h0000_0000;
      link_done_q <= 1'b0;
    end else if (!link_done_q) begin
      phase_q <= l_word ? 3'h0 : phase_q + 3'h1;
      if (l_word) begin
        bits_q      <= l_next;
        link_sum_q  <= link_sum_q ^ cfg_data;
        link_done_q <= (l_next >= shadow_bits_q);
      end
    end
  end

  // Falling edges after the last word allow the move to user mode
  always_ff @(negedge cfg_clk or negedge arm_l) begin
    if (!arm_l) begin
      falls_q    <= 2'h0;
      falls_ok_q <= 1'b0;
    end else if (!link_done_q) begin
      falls_q    <= 2'h0;
      falls_ok_q <= 1'b0;
    end else if (!falls_ok_q) begin
      falls_q    <= falls_q + 2'h1;
      falls_ok_q <= (falls_q + 2'h1 == cfg_load_pkg::FALLS_TO_INIT);
    end
  end

endmodule

/* File: rtl/cfg_load_pkg.sv */
/*
  Constants shared by the parallel configuration load port: register map,
  field positions, reset values, clocks-per-word ratios and timing counts.
  Assumes a 100 MHz register clock.
*/
package cfg_load_pkg;

  // Register map, byte addresses
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_IMAGE_BITS = 12'h004;
  localparam logic [11:0] ADDR_STATUS     = 12'h008;
  localparam logic [11:0] ADDR_CHECKSUM   = 12'h00C;

  // Control fields
  localparam int CTRL_WIDTH_LSB   = 0;
  localparam int CTRL_DECOMP_BIT  = 2;
  localparam int CTRL_ENCRYPT_BIT = 3;
  localparam int CTRL_INITPIN_BIT = 4;
  localparam int CTRL_USERCLK_BIT = 5;
  localparam int CTRL_BITS        = 6;
  localparam logic [5:0]  CTRL_RESET       = 6'h00;
  localparam logic [31:0] IMAGE_BITS_RESET = 32'h0833_97A0;

  // Bus width codes
  localparam logic [1:0] WIDTH_X8  = 2'h0;
  localparam logic [1:0] WIDTH_X16 = 2'h1;
  localparam logic [1:0] WIDTH_X32 = 2'h2;
  localparam logic [5:0] BITS_X8   = 6'h08;
  localparam logic [5:0] BITS_X16  = 6'h10;
  localparam logic [5:0] BITS_X32  = 6'h20;

  // Clocks per accepted word
  localparam logic [2:0] RATIO_1 = 3'h1;
  localparam logic [2:0] RATIO_2 = 3'h2;
  localparam logic [2:0] RATIO_4 = 3'h4;

  // Timing
  localparam int CLK_PERIOD_NS      = 10;
  localparam int POR_DELAY_US       = 100;
  localparam int POR_DELAY_CYCLES   = (POR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_CLK_MAX_PERIOD_NS = 8;
  localparam int USERCLK_SWITCH_PERIODS = 4;
  localparam int USERCLK_SWITCH_NS  = USERCLK_SWITCH_PERIODS * CFG_CLK_MAX_PERIOD_NS;
  localparam int USERCLK_SWITCH_CYCLES = (USERCLK_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int USERCLK_INIT_EDGES = 8576;
  localparam int OSC_INIT_MIN_US    = 175;
  localparam int OSC_INIT_MAX_US    = 437;
  localparam int OSC_INIT_MIN_CYCLES = (OSC_INIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_INIT_MAX_CYCLES = (OSC_INIT_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam logic [1:0] FALLS_TO_INIT = 2'h2;

  typedef enum logic [2:0] {
    ST_POR    = 3'b000,
    ST_RESET  = 3'b001,
    ST_LOAD   = 3'b010,
    ST_INIT   = 3'b011,
    ST_USER   = 3'b100
  } cfg_state_t;

  function automatic logic [2:0] ratio_of(input logic [1:0] width, input logic decomp, input logic encrypt);
    logic [2:0] r;
    r = RATIO_1;
    if (width == WIDTH_X8) begin
      r = decomp ? RATIO_2 : RATIO_1;
    end else begin
      r = decomp ? RATIO_4 : (encrypt ? RATIO_2 : RATIO_1);
    end
    return r;
  endfunction

  function automatic logic [5:0] bits_of(input logic [1:0] width);
    logic [5:0] b;
    b = BITS_X8;
    if (width == WIDTH_X16) begin
      b = BITS_X16;
    end else if (width == WIDTH_X32) begin
      b = BITS_X32;
    end
    return b;
  endfunction

endpackage

/* File: rtl/sync2.sv */
/*
  Two-flop level synchroniser, one flop pair per bit.
  Assumes every bit is a slow level or a handshake qualifier.
*/
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* File: dv/cfg_load_port_props.sv */
/*
  Port checker for cfg_load_port, bound to every instance.
  Assumes open-drain pins resolved with pull-ups outside the port.
*/
`timescale 1ns/100ps
module cfg_load_port_props #(
  parameter int POR_CYCLES  = 20,
  parameter int INIT_CYCLES = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic config_req_n,
  input wire logic status_n_i,
  input wire logic status_n_oe_n,
  input wire logic load_done_i,
  input wire logic load_done_oe_n,
  input wire logic init_done_oe_n,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] por_q;
  logic [31:0] done_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_q  <= '0;
      done_q <= '0;
    end else begin
      por_q  <= (por_q < POR_CYCLES) ? por_q + 32'h1 : por_q;
      done_q <= load_done_i ? done_q + 32'h1 : '0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_user; $rose(init_done_oe_n) && config_req_n; endsequence
  property p_por_status; (por_q < POR_CYCLES) |-> !status_n_oe_n; endproperty
  property p_por_done; (por_q < POR_CYCLES) |-> !load_done_oe_n; endproperty
  property p_req_status; $fell(config_req_n) |-> ##[1:60] !status_n_oe_n; endproperty
  property p_req_done; !config_req_n [*8] |-> !load_done_oe_n; endproperty
  property p_done_release; $rose(load_done_oe_n) |-> config_req_n && status_n_i; endproperty
  property p_init_release; s_user |-> load_done_i; endproperty
  property p_init_time; s_user |-> done_q >= INIT_CYCLES; endproperty
  property p_user_pins; s_user |-> status_n_oe_n && load_done_oe_n; endproperty

  a_por_status: assert property (p_por_status) else $error("status released in power-on delay");
  a_por_done: assert property (p_por_done) else $error("load done released in power-on delay");
  a_req_status: assert property (p_req_status) else $error("status not low after request");
  a_req_done: assert property (p_req_done) else $error("load done high during request");
  a_done_release: assert property (p_done_release) else $error("load done released out of load");
  a_init_release: assert property (p_init_release) else $error("init done released early");
  a_init_time: assert property (p_init_time) else $error("user mode too soon");
  a_user_pins: assert property (p_user_pins) else $error("user mode pins not high");

  c_done: cover property ($rose(load_done_oe_n));
  c_user: cover property (s_user);
  c_err: cover property (pready && pslverr);
endmodule

bind cfg_load_port cfg_load_port_props #(.POR_CYCLES(POR_CYCLES), .INIT_CYCLES(INIT_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .config_req_n(config_req_n), .status_n_i(status_n_i),
  .status_n_oe_n(status_n_oe_n), .load_done_i(load_done_i), .load_done_oe_n(load_done_oe_n),
  .init_done_oe_n(init_done_oe_n), .pready(pready), .pslverr(pslverr));

/* File: dv/cfg_host.sv */
/*
  Configuration host model: drives cfg_clk and the data bus.
  Assumes one caller at a time; clock rests low between words.
*/
`timescale 1ns/100ps
module cfg_host (
  output logic        cfg_clk,
  output logic [31:0] cfg_data
);
  initial begin
    cfg_clk  = 1'b0;
    cfg_data = 32'h0;
  end

  // One word over r clocks, after an optional pause
  task automatic send(input logic [31:0] w, input int r, input int gap);
    cfg_data = w;
    #(3 + gap);
    for (int i = 0; i < r; i++) begin
      cfg_clk = 1'b1;
      #1;
      if (i == r - 1) cfg_data = ~w;
      #2;
      cfg_clk = 1'b0;
      #3;
    end
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      cfg_clk = 1'b1;
      #3;
      cfg_clk = 1'b0;
      #3;
    end
  endtask
endmodule

/* File: dv/fpp_config_load_port_tb.sv */
/*
  Self-checking bench for cfg_load_port: APB map, loads in all modes.
  Assumes the cfg_host model and the bound port checker.
*/
`timescale 1ns/100ps
module fpp_config_load_port_tb;
  localparam int POR  = 20;
  localparam int INIT = 50;
  logic        pclk, presetn, psel, penable, pwrite, config_req_n, user_startup_clk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cfg_data, rd_v;
  logic        pready, pslverr, cfg_clk, err_v, status_n_o, status_n_oe_n;
  logic        load_done_o, load_done_oe_n, init_done_o, init_done_oe_n;
  wire logic   status_n_i, load_done_i, init_done_i;
  wire logic [2:0] pins;
  int          failures, checks, seed, cyc;

  // Pull-ups on the open-drain pins
  assign status_n_i  = status_n_oe_n | status_n_o;
  assign load_done_i = load_done_oe_n | load_done_o;
  assign init_done_i = init_done_oe_n | init_done_o;
  assign pins        = {init_done_i, load_done_i, status_n_i};

  always #5 pclk = ~pclk;
  always #24 user_startup_clk = ~user_startup_clk;
  always @(posedge pclk) cyc <= cyc + 1;

  cfg_host u_host (.cfg_clk(cfg_clk), .cfg_data(cfg_data));
  cfg_load_port #(.POR_CYCLES(POR), .INIT_CYCLES(INIT)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg_clk(cfg_clk),
    .cfg_data(cfg_data), .config_req_n(config_req_n), .user_startup_clk(user_startup_clk),
    .status_n_i(status_n_i), .status_n_o(status_n_o), .status_n_oe_n(status_n_oe_n),
    .load_done_i(load_done_i), .load_done_o(load_done_o), .load_done_oe_n(load_done_oe_n),
    .init_done_i(init_done_i), .init_done_o(init_done_o), .init_done_oe_n(init_done_oe_n));

  function automatic int exp_ratio(input int w, input bit dc, input bit en);
    if (dc) return (w == 0) ? 2 : 4;
    return (w != 0 && en) ? 2 : 1;
  endfunction

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_pin(input int k, input int lim);
    int n;
    n = 0;
    while (pins[k] !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk("pin level", 32'h1, 32'(pins[k]));
    if (pins[k] !== 1'b1) wrap_up();
  endtask

  task automatic load(input int w, input bit dc, input bit en, input bit ip, input bit uc, input int img);
    int r, bits, nw, t, t0, lo, hi;
    logic [31:0] sum, word, mask;
    r = exp_ratio(w, dc, en);
    bits = 8 << w;
    nw = (img + bits - 1) / bits;
    mask = (w == 0) ? 32'h0000_00FF : (w == 1) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    sum = 32'h0;
    apb(1'b1, cfg_load_pkg::ADDR_CTRL, {26'h0, uc, ip, en, dc, 2'(w)}, rd_v, err_v);
    apb(1'b1, cfg_load_pkg::ADDR_IMAGE_BITS, 32'(img), rd_v, err_v);
    @(posedge pclk);
    config_req_n <= 1'b0;
    repeat (8) @(posedge pclk);
    repeat (3) u_host.send($random(seed), 1, 0);
    repeat (200) @(posedge pclk);
    chk("status pin", 32'h0, 32'(status_n_i));
    chk("load done pin", 32'h0, 32'(load_done_i));
    config_req_n <= 1'b1;
    wait_pin(0, 400);
    repeat (8) @(posedge pclk);
    // Two edges for the arming synchroniser
    u_host.pulses(2);
    for (int i = 0; i < nw; i++) begin
      word = $random(seed) & mask;
      if (i == nw - 1) begin
        repeat (8) @(posedge pclk);
        chk("load done early", 32'h0, 32'(load_done_i));
      end
      u_host.send(word, r, ($random(seed) & 3) * 5);
      sum = sum ^ word;
    end
    wait_pin(1, 64);
    t0 = cyc;
    chk("init pin", 32'(!ip), 32'(init_done_i));
    apb(1'b0, cfg_load_pkg::ADDR_CHECKSUM, 32'h0, rd_v, err_v);
    chk("checksum", sum, rd_v);
    u_host.pulses(2);
    t = 0;
    do begin
      apb(1'b0, cfg_load_pkg::ADDR_STATUS, 32'h0, rd_v, err_v);
      t++;
    end while (rd_v[2:0] !== 3'h4 && t < (uc ? 12000 : 60));
    chk("state", 32'h4, {29'h0, rd_v[2:0]});
    if (rd_v[2:0] !== 3'h4) wrap_up();
    t = cyc - t0;
    lo = uc ? cfg_load_pkg::USERCLK_SWITCH_CYCLES + 41160 : INIT;
    hi = uc ? lo + 300 : INIT * 437 / 175;
    chk("init time", 32'h1, 32'(t >= lo && t <= hi));
    chk("user pins", 32'h7, 32'(pins));
  endtask

  initial begin
    int nwr, bits, img;
    pclk = 1'b0;
    user_startup_clk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    config_req_n = 1'b1;
    failures = 0;
    checks = 0;
    seed = 70;
    cyc = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("power-on pins", 32'h4, 32'(pins));
    apb(1'b0, cfg_load_pkg::ADDR_CTRL, 32'h0, rd_v, err_v);
    chk("ctrl reset", 32'(cfg_load_pkg::CTRL_RESET), rd_v);
    apb(1'b0, cfg_load_pkg::ADDR_IMAGE_BITS, 32'h0, rd_v, err_v);
    chk("image bits reset", cfg_load_pkg::IMAGE_BITS_RESET, rd_v);
    apb(1'b1, cfg_load_pkg::ADDR_STATUS, 32'hFFFF_FFFF, rd_v, err_v);
    chk("status write error", 32'h1, 32'(err_v));
    apb(1'b0, 12'h010, 32'h0, rd_v, err_v);
    chk("unmapped error", 32'h1, 32'(err_v));
    chk("unmapped data", 32'h0, rd_v);
    for (int k = 0; k < 12; k++) begin
      nwr = 2 + $unsigned($random(seed)) % 3;
      bits = 8 << (k / 4);
      img = bits * nwr - ((k % 2) ? $unsigned($random(seed)) % bits : 0);
      load(k / 4, k[1], k[0], k % 3 == 0, 1'b0, img);
    end
    load(2, 1'b0, 1'b1, 1'b1, 1'b1, 64);
    wrap_up();
  end
endmodule
